// ---- core/tcc_pkg.sv ----
// Purpose: Constants and types for the timer compare channel.
// Assumes: AHB-Lite register bus, 32-bit words, one aligned word per register.
// Notes: Register offsets are byte addresses.
package tcc_pkg;
	localparam logic [11:0] TCC_OFF_CMP_LO = 12'h000;
	localparam logic [11:0] TCC_OFF_CMP_HI = 12'h004;
	localparam logic [11:0] TCC_OFF_CTRL = 12'h008;
	localparam logic [11:0] TCC_OFF_TSEL1 = 12'h00C;
	localparam logic [11:0] TCC_OFF_TSEL2 = 12'h010;
	localparam logic [11:0] TCC_OFF_FLAG = 12'h014;
	localparam logic [11:0] TCC_OFF_IEN = 12'h018;
	localparam logic [11:0] TCC_OFF_STAT = 12'h01C;
	localparam int TCC_ADDR_W = 12;
	localparam int TCC_TMR_W = 16;
	localparam int TCC_FLAG_BIT = 1;
	localparam logic [7:0] TCC_CTRL_MASK = 8'h3F;
	localparam logic [7:0] TCC_TSEL1_MASK = 8'hD7;
	localparam logic [7:0] TCC_TSEL2_MASK = 8'h17;
	localparam logic [7:0] TCC_FLAG_MASK = 8'h02;
	localparam logic [7:0] TCC_RST_BYTE = 8'h00;
	localparam logic [3:0] TCC_M_SET = 4'h8;
	localparam logic [3:0] TCC_M_CLR = 4'h9;
	localparam logic [3:0] TCC_M_SWI = 4'hA;
	localparam logic [3:0] TCC_M_SPEC = 4'hB;
	localparam logic [3:0] TCC_M_TOG = 4'h2;
	localparam logic [1:0] TCC_HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] TCC_HTRANS_SEQ = 2'b11;
	localparam logic [2:0] TCC_HSIZE_WORD = 3'b010;
	typedef enum {TCC_ACT_NONE, TCC_ACT_HIGH, TCC_ACT_LOW, TCC_ACT_TOGGLE} tcc_act_t;
	typedef struct packed {
		logic [TCC_TMR_W-1:0] count;
		logic step;
	} tcc_timer_t;
	typedef struct packed {
		logic [TCC_ADDR_W-1:0] addr;
		logic write;
	} tcc_bus_req_t;
endpackage : tcc_pkg

// ---- core/tcc_ahb_slave.sv ----
// Purpose: AHB-Lite slave front end, zero wait states.
// Assumes: Single word transfers only; response always OKAY.
// Notes: Write strobe lands in the data phase together with hwdata.
`timescale 1ns/100ps
module tcc_ahb_slave
	import tcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output tcc_bus_req_t dphase,
	output logic wr_stb,
	output logic rd_stb
);
	tcc_bus_req_t req_q;
	logic valid_q;
	wire logic take = hsel && hready && (htrans == TCC_HTRANS_NONSEQ || htrans == TCC_HTRANS_SEQ)
		&& hsize == TCC_HSIZE_WORD;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_q <= '0;
			valid_q <= 1'b0;
		end else if (hready) begin
			valid_q <= take;
			req_q <= '{addr: haddr[TCC_ADDR_W-1:0], write: hwrite};
		end
	end
	assign dphase = req_q;
	assign wr_stb = valid_q && req_q.write;
	assign rd_stb = valid_q && !req_q.write;
endmodule : tcc_ahb_slave

// ---- core/tcc_match_det.sv ----
// Purpose: Equality detector firing once per timer step.
// Assumes: Timer steps arrive as one-cycle enables on the system clock.
// Notes: A stalled timer equal to the compare value fires only once.
`timescale 1ns/100ps
module tcc_match_det
	import tcc_pkg::*;
#(
	parameter int W = TCC_TMR_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] count,
	input wire logic [W-1:0] value,
	input wire logic timer_chg,
	input wire logic value_chg,
	input wire logic enable,
	output logic hit
);
	logic armed_q;
	wire logic equal = (count == value);
	// Re-arm after any change of either operand
	wire logic armed_d = timer_chg || value_chg || !equal || !enable ? 1'b1 : 1'b0;
	assign hit = enable && equal && armed_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armed_q <= 1'b1;
		end else begin
			armed_q <= hit ? 1'b0 : (armed_d | armed_q);
		end
	end
endmodule : tcc_match_det

// ---- core/tcc_top.sv ----
// Purpose: One compare channel with AHB-Lite registers and interrupt.
// Assumes: Both timebases run on SYS_CLK and give their counts as inputs.
// Notes: Capture and PWM modes are not built; those modes only hold settings.
`timescale 1ns/100ps
module tcc_top
	import tcc_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [TCC_TMR_W-1:0] TIMEBASE_A_COUNT,
	input wire logic [TCC_TMR_W-1:0] TIMEBASE_B_COUNT,
	input wire logic ADC_ENABLED,
	output logic CMP_PIN,
	output logic TIMEBASE_A_RESET,
	output logic TIMEBASE_B_RESET,
	output logic SPECIAL_TRIGGER,
	output logic ADC_START,
	output logic IRQ
);
	tcc_bus_req_t dph;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] cmp_lo_q;
	logic [7:0] cmp_hi_q;
	logic [7:0] ctrl_q;
	logic [7:0] tsel1_q;
	logic [7:0] tsel2_q;
	logic [7:0] flag_q;
	logic [7:0] ien_q;
	logic latch_q;
	logic trig_q;
	logic rst_a_q;
	logic rst_b_q;
	logic irq_q;
	logic [31:0] rdata_q;
	logic [TCC_TMR_W-1:0] cnt_prev_q;
	logic [1:0] tsel_prev_q;
	logic hit;
	tcc_act_t act;

	tcc_ahb_slave u_bus (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.hsel(HSEL),
		.haddr(HADDR),
		.htrans(HTRANS),
		.hwrite(HWRITE),
		.hsize(HSIZE),
		.hready(HREADY),
		.dphase(dph),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb)
	);

	wire logic [7:0] wbyte = HWDATA[7:0];
	wire logic wr_cmp_lo = wr_stb && dph.addr == TCC_OFF_CMP_LO;
	wire logic wr_cmp_hi = wr_stb && dph.addr == TCC_OFF_CMP_HI;
	wire logic wr_ctrl = wr_stb && dph.addr == TCC_OFF_CTRL;
	wire logic wr_tsel1 = wr_stb && dph.addr == TCC_OFF_TSEL1;
	wire logic wr_tsel2 = wr_stb && dph.addr == TCC_OFF_TSEL2;
	wire logic wr_flag = wr_stb && dph.addr == TCC_OFF_FLAG;
	wire logic wr_ien = wr_stb && dph.addr == TCC_OFF_IEN;

	wire logic [3:0] mode = ctrl_q[3:0];
	wire logic [1:0] tsel = tsel1_q[1:0];
	// Reserved select 11 leaves the channel without a timebase
	wire logic use_a = (tsel == 2'b00);
	wire logic use_b = (tsel == 2'b01) || (tsel == 2'b10);
	wire logic [TCC_TMR_W-1:0] cnt = use_a ? TIMEBASE_A_COUNT : TIMEBASE_B_COUNT;
	wire logic is_cmp = (mode == TCC_M_TOG) || (mode == TCC_M_SET) || (mode == TCC_M_CLR)
		|| (mode == TCC_M_SWI) || (mode == TCC_M_SPEC);
	wire logic cmp_en = is_cmp && (use_a || use_b);
	wire logic [TCC_TMR_W-1:0] cmp_val = {cmp_hi_q, cmp_lo_q};
	wire logic timer_chg = (cnt != cnt_prev_q) || (tsel != tsel_prev_q);
	wire logic value_chg = wr_cmp_lo || wr_cmp_hi || wr_ctrl;

	tcc_match_det #(
		.W(TCC_TMR_W)
	) u_det (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.count(cnt),
		.value(cmp_val),
		.timer_chg(timer_chg),
		.value_chg(value_chg),
		.enable(cmp_en),
		.hit(hit)
	);

	always_comb begin
		case (mode)
			TCC_M_SET: act = TCC_ACT_HIGH;
			TCC_M_CLR: act = TCC_ACT_LOW;
			TCC_M_TOG: act = TCC_ACT_TOGGLE;
			TCC_M_SWI: act = TCC_ACT_NONE;
			default: act = TCC_ACT_NONE;
		endcase
	end

	wire logic ctrl_zero = wr_ctrl && (wbyte == 8'h00);
	wire logic latch_d = ctrl_zero ? 1'b0 :
		!hit ? latch_q :
		act == TCC_ACT_HIGH ? 1'b1 :
		act == TCC_ACT_LOW ? 1'b0 :
		act == TCC_ACT_TOGGLE ? !latch_q : latch_q;
	wire logic spec_hit = hit && (mode == TCC_M_SPEC);
	// Set beats a software clear landing in the same cycle
	wire logic [7:0] flag_clr = wr_flag ? ~wbyte : 8'h00;
	wire logic [7:0] flag_set = {6'h00, hit, 1'b0};
	wire logic [7:0] flag_d = ((flag_q & ~flag_clr) | flag_set) & TCC_FLAG_MASK;
	wire logic irq_d = |(flag_d & ien_q & TCC_FLAG_MASK);

	wire logic [7:0] rd_byte = dph.addr == TCC_OFF_CMP_LO ? cmp_lo_q :
		dph.addr == TCC_OFF_CMP_HI ? cmp_hi_q :
		dph.addr == TCC_OFF_CTRL ? ctrl_q :
		dph.addr == TCC_OFF_TSEL1 ? tsel1_q :
		dph.addr == TCC_OFF_TSEL2 ? tsel2_q :
		dph.addr == TCC_OFF_FLAG ? flag_q :
		dph.addr == TCC_OFF_IEN ? ien_q :
		dph.addr == TCC_OFF_STAT ? {7'h00, latch_q} : 8'h00;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cmp_lo_q <= TCC_RST_BYTE;
			cmp_hi_q <= TCC_RST_BYTE;
			ctrl_q <= TCC_RST_BYTE;
			tsel1_q <= TCC_RST_BYTE;
			tsel2_q <= TCC_RST_BYTE;
			ien_q <= TCC_RST_BYTE;
		end else begin
			if (wr_cmp_lo) cmp_lo_q <= wbyte;
			if (wr_cmp_hi) cmp_hi_q <= wbyte;
			if (wr_ctrl) ctrl_q <= wbyte & TCC_CTRL_MASK;
			if (wr_tsel1) tsel1_q <= wbyte & TCC_TSEL1_MASK;
			if (wr_tsel2) tsel2_q <= wbyte & TCC_TSEL2_MASK;
			if (wr_ien) ien_q <= wbyte & TCC_FLAG_MASK;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			flag_q <= TCC_RST_BYTE;
			latch_q <= 1'b0;
			trig_q <= 1'b0;
			rst_a_q <= 1'b0;
			rst_b_q <= 1'b0;
			irq_q <= 1'b0;
			cnt_prev_q <= '0;
			tsel_prev_q <= 2'b00;
		end else begin
			flag_q <= flag_d;
			latch_q <= latch_d;
			trig_q <= spec_hit;
			rst_a_q <= spec_hit && use_a;
			rst_b_q <= spec_hit && use_b;
			irq_q <= irq_d;
			cnt_prev_q <= cnt;
			tsel_prev_q <= tsel;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= (rd_stb || wr_stb) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Read data follows the data phase; bus runs without wait states
	assign HRDATA = rd_stb ? {24'h00_0000, rd_byte} : rdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign CMP_PIN = latch_q;
	assign TIMEBASE_A_RESET = rst_a_q;
	assign TIMEBASE_B_RESET = rst_b_q;
	assign SPECIAL_TRIGGER = trig_q;
	// Basic channel never starts a conversion, whatever the converter state
	assign ADC_START = 1'b0 & ADC_ENABLED;
	assign IRQ = irq_q;
endmodule : tcc_top

// ---- testbench/tcc_timer_model.sv ----
// Purpose: Timebase counter model for the compare channel.
// Assumes: Counts on SYS_CLK only.
// Notes: Load sets the count directly, for corner cases.
`timescale 1ns/100ps
module tcc_timer_model
	import tcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic load,
	input wire logic [TCC_TMR_W-1:0] load_val,
	input wire logic clear,
	output logic [TCC_TMR_W-1:0] count
);
	// Synchronous counting only; an asynchronous count would break compare
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) count <= '0;
		else if (clear) count <= '0;
		else if (load) count <= load_val;
		else if (run) count <= count + 1'b1;
	end
endmodule : tcc_timer_model

// ---- testbench/tcc_assertions.sv ----
// Purpose: Port checks of the compare channel.
// Assumes: One clock, RST_B async active low.
// Notes: Bound to tcc_top.
`timescale 1ns/100ps
module tcc_assertions
	import tcc_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic CMP_PIN,
	input wire logic TIMEBASE_A_RESET,
	input wire logic TIMEBASE_B_RESET,
	input wire logic SPECIAL_TRIGGER,
	input wire logic ADC_START,
	input wire logic IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	logic wr_dp_q;
	wire logic aph = HSEL && HREADYOUT && HTRANS[1];
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) wr_dp_q <= 1'b0;
		else wr_dp_q <= aph && HWRITE;
	end
	sequence s_acc(logic [11:0] a, logic w);
		aph && HADDR == {20'h00000, a} && HWRITE == w;
	endsequence
	sequence s_ctrl_clear;
		s_acc(TCC_OFF_CTRL, 1'b1) ##1 HWDATA[7:0] == 8'h00;
	endsequence
	AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
		else $error("bus not okay");
	AST_CTRL_CLEAR: assert property (s_ctrl_clear |=> !CMP_PIN)
		else $error("pin not low after control clear");
	AST_CTRL_READ: assert property (s_acc(TCC_OFF_CTRL, 1'b0) |=> HRDATA[31:6] == 26'h0)
		else $error("control upper bits set");
	AST_STAT_PIN: assert property (s_acc(TCC_OFF_STAT, 1'b0) |=> HRDATA == {31'h0, CMP_PIN})
		else $error("status differs from pin");
	AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(wr_dp_q))
		else $error("irq dropped without write");
	AST_TRIG_PULSE: assert property (SPECIAL_TRIGGER |=> !SPECIAL_TRIGGER)
		else $error("trigger longer than a cycle");
	AST_TRIG_RESET: assert property (SPECIAL_TRIGGER |-> TIMEBASE_A_RESET ^ TIMEBASE_B_RESET)
		else $error("trigger without one timer reset");
	AST_RESET_CAUSE: assert property (TIMEBASE_A_RESET || TIMEBASE_B_RESET |-> SPECIAL_TRIGGER)
		else $error("timer reset without trigger");
	AST_NO_ADC: assert property (!ADC_START)
		else $error("converter start seen");
endmodule : tcc_assertions
bind tcc_top tcc_assertions u_tcc_chk (.SYS_CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE,
	.HWDATA, .HRDATA, .HREADYOUT, .HRESP, .CMP_PIN, .TIMEBASE_A_RESET, .TIMEBASE_B_RESET,
	.SPECIAL_TRIGGER, .ADC_START, .IRQ);

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench of the compare channel.
// Assumes: Timer models drive both timebases.
// Notes: Compare values random from a fixed seed.
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module testbench
	import tcc_pkg::*;
;
	logic SYS_CLK = 1'b0, RST_B = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, ADC_ENABLED = 1'b0;
	logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, rd;
	logic [1:0] HTRANS = '0, run = '0, load = '0;
	logic [2:0] HSIZE = TCC_HSIZE_WORD;
	logic HREADYOUT, HRESP, CMP_PIN, TIMEBASE_A_RESET, TIMEBASE_B_RESET, SPECIAL_TRIGGER;
	logic ADC_START, IRQ, pin_e = 1'b0;
	logic [15:0] TIMEBASE_A_COUNT, TIMEBASE_B_COUNT, cv, load_val = '0;
	wire logic HREADY = HREADYOUT;
	int mismatches = 0, n_checks = 0, seed = 32'h15A54405;
	// Offset and readback mask after writing all ones
	logic [19:0] rg [9] = '{20'h000FF, 20'h004FF, 20'h0083F, 20'h00CD7, 20'h01017, 20'h01400,
		20'h01802, 20'h01C00, 20'h02000};
	// Enable, select and mode per match test
	logic [11:0] tbl [11] = '{12'h108, 12'h012, 12'h129, 12'h102, 12'h01A, 12'h10A, 12'h12B,
		12'h01B, 12'h10B, 12'h132, 12'h108};
	always #25 SYS_CLK = ~SYS_CLK;
	tcc_top DUT (.SYS_CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
		.HRDATA, .HREADYOUT, .HRESP, .TIMEBASE_A_COUNT, .TIMEBASE_B_COUNT, .ADC_ENABLED,
		.CMP_PIN, .TIMEBASE_A_RESET, .TIMEBASE_B_RESET, .SPECIAL_TRIGGER, .ADC_START, .IRQ);
	tcc_timer_model u_tmr_a (.clk(SYS_CLK), .rst_b(RST_B), .run(run[0]), .load(load[0]),
		.load_val, .clear(TIMEBASE_A_RESET), .count(TIMEBASE_A_COUNT));
	tcc_timer_model u_tmr_b (.clk(SYS_CLK), .rst_b(RST_B), .run(run[1]), .load(load[1]),
		.load_val, .clear(TIMEBASE_B_RESET), .count(TIMEBASE_B_COUNT));
	function automatic logic exp_pin(input logic [3:0] m, input logic p);
		return (m == TCC_M_SET) || (m == TCC_M_TOG ? !p : m != TCC_M_CLR && p);
	endfunction : exp_pin
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= TCC_HTRANS_NONSEQ;
		HADDR <= {20'h00000, a};
		HWRITE <= w;
		do @(posedge SYS_CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= d;
		do @(posedge SYS_CLK); while (HREADY !== 1'b1);
		rd = HRDATA;
	endtask : bus
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK("read", e, rd)
	endtask : rchk
	task automatic run_match(input logic [3:0] m, input logic [1:0] sel, input logic ien);
		logic b;
		logic hit;
		int k;
		b = sel != 2'b00;
		hit = sel != 2'b11;
		// Bit 8 set keeps the value clear of a freshly reset timer
		cv = 16'($random(seed)) | 16'h0100;
		load <= 2'b11;
		load_val <= cv - 16'h0006;
		ADC_ENABLED <= 1'($random(seed));
		@(posedge SYS_CLK);
		load <= 2'b00;
		bus(1'b1, TCC_OFF_TSEL1, {30'h0, sel});
		bus(1'b1, TCC_OFF_IEN, {30'h0, ien, 1'b0});
		bus(1'b1, TCC_OFF_CMP_LO, {24'h0, cv[7:0]});
		bus(1'b1, TCC_OFF_CMP_HI, {24'h0, cv[15:8]});
		bus(1'b1, TCC_OFF_CTRL, {28'h0, m});
		for (k = 0; k < 300 && (b ? TIMEBASE_B_COUNT : TIMEBASE_A_COUNT) !== cv; k++) begin
			run <= {b, !b} & {2{1'($random(seed))}};
			@(posedge SYS_CLK);
		end
		run <= 2'b00;
		`CHK("timer reach", 1'b1, k < 300)
		if (hit) pin_e = exp_pin(m, pin_e);
		#1;
		`CHK("pin", pin_e, CMP_PIN)
		`CHK("trigger", hit && m == TCC_M_SPEC, SPECIAL_TRIGGER)
		`CHK("reset b", hit && m == TCC_M_SPEC && b, TIMEBASE_B_RESET)
		`CHK("reset a", hit && m == TCC_M_SPEC && !b, TIMEBASE_A_RESET)
		`CHK("adc start", 1'b0, ADC_START)
		`CHK("irq", hit && ien, IRQ)
		repeat (5) @(posedge SYS_CLK);
		`CHK("pin held", pin_e, CMP_PIN)
		rchk(TCC_OFF_FLAG, {30'h0, hit, 1'b0});
		rchk(TCC_OFF_STAT, {31'h0, pin_e});
		bus(1'b1, TCC_OFF_FLAG, 32'h0);
		rchk(TCC_OFF_IEN, {30'h0, ien, 1'b0});
		`CHK("irq clear", 1'b0, IRQ)
		$display("test mode %0h sel %0d done", m, sel);
	endtask : run_match
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (10) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		foreach (rg[i]) begin
			rchk(rg[i][19:8], 32'h0);
			bus(1'b1, rg[i][19:8], 32'hFFFF_FFFF);
			rchk(rg[i][19:8], {24'h0, rg[i][7:0]});
		end
		$display("test registers done");
		foreach (tbl[i]) run_match(tbl[i][3:0], tbl[i][5:4], tbl[i][8]);
		bus(1'b1, TCC_OFF_CTRL, 32'h0);
		rchk(TCC_OFF_STAT, 32'h0);
		bus(1'b1, TCC_OFF_CTRL, 32'h0000_00F5);
		rchk(TCC_OFF_CTRL, 32'h0000_0035);
		rchk(TCC_OFF_STAT, 32'h0);
		$display("test control clear done");
		print_verdict();
	end
	initial begin
		#1000000;
		mismatches++;
		print_verdict();
	end
endmodule : testbench
